/* inc/cpu_regs_pkg.sv */
// Shared constants, types and the state layout of the CPU register file.
package cpu_regs_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // Register bus offsets, one 16-bit register per index.
   localparam logic [ADDR_W-1:0] OFS_PROGRAM_COUNTER   = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_ACCUMULATOR       = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_TEMPORARY_OPERAND = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_INDEX_REGISTER    = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_EXTRA_POINTER     = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_STACK_POINTER     = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_PROGRAM_STATUS    = 4'h6;

   // Bit positions inside the condition code byte.
   localparam int CC_CARRY    = 0;
   localparam int CC_OVERFLOW = 1;
   localparam int CC_ZERO     = 2;
   localparam int CC_NEGATIVE = 3;
   localparam int CC_IL_LO    = 4;
   localparam int CC_IL_HI    = 5;
   localparam int CC_IRQ_EN   = 6;
   localparam int CC_HALF     = 7;

   // Bank field width; bank pointer bits above it are reserved and read zero.
   localparam int BANK_W       = 5;
   localparam int BANK_LO      = 8;
   localparam int GPR_NUM_W    = 3;
   localparam logic [15:0] PS_WRITE_MASK = 16'h1fff;

   localparam logic [15:0] RESET_WORD    = 16'h0000;
   localparam logic [1:0]  IL_NONE       = 2'h3;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;

   typedef enum logic [2:0] {
      ALU_ADD  = 3'h0,
      ALU_SUB  = 3'h1,
      ALU_SHL  = 3'h2,
      ALU_SHR  = 3'h3
   } alu_op_type;

   typedef enum logic [1:0] {
      REGION_IO   = 2'h0,
      REGION_DATA = 2'h1,
      REGION_PROG = 2'h2,
      REGION_GAP  = 2'h3
   } region_type;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } bus_req_type;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] sel;
      logic [DATA_W-1:0] data;
   } dp_wr_type;

   typedef struct packed {
      logic       valid;
      alu_op_type op;
      logic       byte_op;
   } alu_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] program_counter;
      logic [DATA_W-1:0] accumulator;
      logic [DATA_W-1:0] temporary_operand;
      logic [DATA_W-1:0] index_register;
      logic [DATA_W-1:0] extra_pointer;
      logic [DATA_W-1:0] stack_pointer;
      logic [DATA_W-1:0] program_status;
   } reg_file_type;

   typedef struct packed {
      reg_file_type      regs;
      logic [DATA_W-1:0] rdata;
      logic [DATA_W-1:0] idx_addr;
      logic [DATA_W-1:0] gpr_addr;
      region_type        region;
      logic              irq_take;
   } core_state_type;

endpackage

/* rtl/cpu_registers.sv */
// Architectural register set, condition codes and address helpers of the CPU.
//
// Summary of operation
// - A 16-bit program counter holds the address of the instruction being fetched.
// - A 16-bit accumulator takes results; byte operations touch only its low byte.
// - A 16-bit temporary operand is the second operand; byte operations use its low byte.
// - A 16-bit index register is added to a displacement to form indexed addresses.
// - A 16-bit extra pointer supplies a memory address for pointer access.
// - A 16-bit stack pointer marks the current stack location in data memory.
// - Program status is bank pointer in the upper byte, condition codes below.
// - Add and subtract set half carry on carry or borrow between bits 3 and 4, else clear it; shifts leave it.
// - Interrupt enable permits interrupts when one, blocks them when zero, resets to zero.
// - Interrupts are taken only above the level field; level three admits none.
// - Negative flag copies the most significant bit of the result.
// - Zero flag is set for a zero result and cleared otherwise.
// - Add and subtract set the overflow flag on two's-complement overflow, else clear it; shifts leave it.
// - Carry flag takes carry or borrow out of the top bit, or the shifted-out bit.
// - General registers live in data memory in banks of eight, up to 32 banks.
// - One 64-Kbyte space: I/O lowest, data memory above, program memory highest.
//
// Chosen here: the address map and the address-and-strobe port.
module cpu_registers
#(
   parameter logic [15:0] PC_RESET   = 16'h0000,
   parameter logic [15:0] GPR_BASE   = 16'h0100,
   parameter logic [15:0] IO_LAST    = 16'h007f,
   parameter logic [15:0] DATA_LAST  = 16'h047f,
   parameter logic [15:0] PROG_FIRST = 16'h8000
)
(
   input  wire logic                                 ref_clk,
   input  wire logic                                 resetn,
   input  wire cpu_regs_pkg::bus_req_type            bus,
   output      logic [cpu_regs_pkg::DATA_W-1:0]      bus_rdata,
   input  wire cpu_regs_pkg::dp_wr_type              dp_wr,
   input  wire cpu_regs_pkg::alu_req_type            alu,
   input  wire logic                                 pc_step,
   input  wire logic [cpu_regs_pkg::DATA_W-1:0]      idx_disp,
   input  wire logic [cpu_regs_pkg::GPR_NUM_W-1:0]   gpr_num,
   input  wire logic [cpu_regs_pkg::DATA_W-1:0]      probe_addr,
   input  wire logic                                 irq_req,
   input  wire logic [1:0]                           irq_level,
   output      cpu_regs_pkg::reg_file_type           regs,
   output      logic [cpu_regs_pkg::DATA_W-1:0]      idx_addr,
   output      logic [cpu_regs_pkg::DATA_W-1:0]      gpr_addr,
   output      cpu_regs_pkg::region_type             probe_region,
   output      logic                                 irq_take
);

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   cpu_regs_pkg::core_state_type state_r;
   cpu_regs_pkg::core_state_type state_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Register write helper shared by the bus and the datapath port.

   function automatic cpu_regs_pkg::reg_file_type write_reg
   (
      input cpu_regs_pkg::reg_file_type                rf,
      input logic [cpu_regs_pkg::ADDR_W-1:0]           sel,
      input logic [cpu_regs_pkg::DATA_W-1:0]           data
   );
      cpu_regs_pkg::reg_file_type res;
      res = rf;
      case (sel)
         cpu_regs_pkg::OFS_PROGRAM_COUNTER:
         begin
            res.program_counter = data;
         end
         cpu_regs_pkg::OFS_ACCUMULATOR:
         begin
            res.accumulator = data;
         end
         cpu_regs_pkg::OFS_TEMPORARY_OPERAND:
         begin
            res.temporary_operand = data;
         end
         cpu_regs_pkg::OFS_INDEX_REGISTER:
         begin
            res.index_register = data;
         end
         cpu_regs_pkg::OFS_EXTRA_POINTER:
         begin
            res.extra_pointer = data;
         end
         cpu_regs_pkg::OFS_STACK_POINTER:
         begin
            res.stack_pointer = data;
         end
         cpu_regs_pkg::OFS_PROGRAM_STATUS:
         begin
            res.program_status = data & cpu_regs_pkg::PS_WRITE_MASK;
         end
         default:
         begin
            res = rf;
         end
      endcase
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register read mux.

   function automatic logic [cpu_regs_pkg::DATA_W-1:0] read_reg
   (
      input cpu_regs_pkg::reg_file_type                rf,
      input logic [cpu_regs_pkg::ADDR_W-1:0]           sel
   );
      logic [cpu_regs_pkg::DATA_W-1:0] res;
      res = cpu_regs_pkg::RESET_WORD;
      case (sel)
         cpu_regs_pkg::OFS_PROGRAM_COUNTER:
         begin
            res = rf.program_counter;
         end
         cpu_regs_pkg::OFS_ACCUMULATOR:
         begin
            res = rf.accumulator;
         end
         cpu_regs_pkg::OFS_TEMPORARY_OPERAND:
         begin
            res = rf.temporary_operand;
         end
         cpu_regs_pkg::OFS_INDEX_REGISTER:
         begin
            res = rf.index_register;
         end
         cpu_regs_pkg::OFS_EXTRA_POINTER:
         begin
            res = rf.extra_pointer;
         end
         cpu_regs_pkg::OFS_STACK_POINTER:
         begin
            res = rf.stack_pointer;
         end
         cpu_regs_pkg::OFS_PROGRAM_STATUS:
         begin
            res = rf.program_status;
         end
         default:
         begin
            res = cpu_regs_pkg::RESET_WORD;
         end
      endcase
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Arithmetic unit working on the accumulator and the temporary operand.

   logic [15:0] opa;
   logic [15:0] opb;
   logic [16:0] sum;
   logic [16:0] dif;
   logic [4:0]  half_sum;
   logic [15:0] raw;
   logic [15:0] alu_res;
   logic        carry;
   logic        half;
   logic        ovf;
   logic        sign_a;
   logic        sign_b;
   logic        sign_r;
   logic        is_zero;
   logic        is_arith;

   always_comb
   begin
      // Byte operations see the upper bytes as zero, so carries land in bit 8.
      if (alu.byte_op)
      begin
         opa = {cpu_regs_pkg::BYTE_ZERO, state_r.regs.accumulator[7:0]};
         opb = {cpu_regs_pkg::BYTE_ZERO, state_r.regs.temporary_operand[7:0]};
      end
      else
      begin
         opa = state_r.regs.accumulator;
         opb = state_r.regs.temporary_operand;
      end
      sum = {1'b0, opa} + {1'b0, opb};
      dif = {1'b0, opa} - {1'b0, opb};
      if (alu.op == cpu_regs_pkg::ALU_SUB)
      begin
         half_sum = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
      end
      else
      begin
         half_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
      end
      half = half_sum[4];
      if (alu.byte_op)
      begin
         sign_a = opa[7];
         sign_b = opb[7];
      end
      else
      begin
         sign_a = opa[15];
         sign_b = opb[15];
      end
      is_arith = 1'b1;
      case (alu.op)
         cpu_regs_pkg::ALU_ADD:
         begin
            raw = sum[15:0];
            carry = alu.byte_op ? sum[8] : sum[16];
         end
         cpu_regs_pkg::ALU_SUB:
         begin
            raw = dif[15:0];
            carry = alu.byte_op ? dif[8] : dif[16];
         end
         cpu_regs_pkg::ALU_SHL:
         begin
            raw = {opa[14:0], 1'b0};
            carry = sign_a;
            is_arith = 1'b0;
         end
         cpu_regs_pkg::ALU_SHR:
         begin
            raw = {1'b0, opa[15:1]};
            carry = opa[0];
            is_arith = 1'b0;
         end
         default:
         begin
            raw = opa;
            carry = 1'b0;
            is_arith = 1'b0;
         end
      endcase
      if (alu.byte_op)
      begin
         sign_r = raw[7];
         is_zero = (raw[7:0] == cpu_regs_pkg::BYTE_ZERO);
      end
      else
      begin
         sign_r = raw[15];
         is_zero = (raw == cpu_regs_pkg::RESET_WORD);
      end
      if (alu.op == cpu_regs_pkg::ALU_SUB)
      begin
         ovf = (sign_a != sign_b) && (sign_r != sign_a);
      end
      else
      begin
         ovf = (sign_a == sign_b) && (sign_r != sign_a);
      end
      // A byte result leaves the upper accumulator byte exactly as it was.
      if (alu.byte_op)
      begin
         alu_res = {state_r.regs.accumulator[15:8], raw[7:0]};
      end
      else
      begin
         alu_res = raw;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state.

   logic [1:0]              cur_level;
   logic [cpu_regs_pkg::BANK_W-1:0] bank;
   logic [15:0]             bank_ofs;

   always_comb
   begin
      state_nxt = state_r;
      cur_level = state_r.regs.program_status[cpu_regs_pkg::CC_IL_HI:cpu_regs_pkg::CC_IL_LO];
      bank = state_r.regs.program_status[cpu_regs_pkg::BANK_LO +: cpu_regs_pkg::BANK_W];
      bank_ofs = {8'h00, bank, 3'h0};

      // Later sources win: bus write, then datapath write or, without one, step, then ALU result and flags.
      if (bus.wr)
      begin
         state_nxt.regs = write_reg(state_nxt.regs, bus.addr, bus.wdata);
      end
      if (dp_wr.valid)
      begin
         state_nxt.regs = write_reg(state_nxt.regs, dp_wr.sel, dp_wr.data);
      end
      else if (pc_step)
      begin
         state_nxt.regs.program_counter = state_r.regs.program_counter + 16'h0001;
      end

      if (alu.valid)
      begin
         state_nxt.regs.accumulator = alu_res;
         if (is_arith)
         begin
            state_nxt.regs.program_status[cpu_regs_pkg::CC_HALF] = half;
            state_nxt.regs.program_status[cpu_regs_pkg::CC_OVERFLOW] = ovf;
         end
         state_nxt.regs.program_status[cpu_regs_pkg::CC_NEGATIVE] = sign_r;
         state_nxt.regs.program_status[cpu_regs_pkg::CC_ZERO] = is_zero;
         state_nxt.regs.program_status[cpu_regs_pkg::CC_CARRY] = carry;
      end

      // Read data stands for one cycle and is zero otherwise.
      if (bus.rd)
      begin
         state_nxt.rdata = read_reg(state_r.regs, bus.addr);
      end
      else
      begin
         state_nxt.rdata = cpu_regs_pkg::RESET_WORD;
      end

      state_nxt.idx_addr = state_r.regs.index_register + idx_disp;
      state_nxt.gpr_addr = GPR_BASE + bank_ofs + {13'h0000, gpr_num};

      if (probe_addr <= IO_LAST)
      begin
         state_nxt.region = cpu_regs_pkg::REGION_IO;
      end
      else if (probe_addr <= DATA_LAST)
      begin
         state_nxt.region = cpu_regs_pkg::REGION_DATA;
      end
      else if (probe_addr >= PROG_FIRST)
      begin
         state_nxt.region = cpu_regs_pkg::REGION_PROG;
      end
      else
      begin
         state_nxt.region = cpu_regs_pkg::REGION_GAP;
      end

      // Lower level numbers are higher priority; a field of three blocks all.
      state_nxt.irq_take = irq_req
                        && state_r.regs.program_status[cpu_regs_pkg::CC_IRQ_EN]
                        && (cur_level != cpu_regs_pkg::IL_NONE)
                        && (irq_level < cur_level);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r.regs.program_counter   <= PC_RESET;
         state_r.regs.accumulator       <= cpu_regs_pkg::RESET_WORD;
         state_r.regs.temporary_operand <= cpu_regs_pkg::RESET_WORD;
         state_r.regs.index_register    <= cpu_regs_pkg::RESET_WORD;
         state_r.regs.extra_pointer     <= cpu_regs_pkg::RESET_WORD;
         state_r.regs.stack_pointer     <= cpu_regs_pkg::RESET_WORD;
         state_r.regs.program_status    <= cpu_regs_pkg::RESET_WORD;
         state_r.rdata                  <= cpu_regs_pkg::RESET_WORD;
         state_r.idx_addr               <= cpu_regs_pkg::RESET_WORD;
         state_r.gpr_addr               <= GPR_BASE;
         state_r.region                 <= cpu_regs_pkg::REGION_IO;
         state_r.irq_take               <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.

   assign bus_rdata    = state_r.rdata;
   assign regs         = state_r.regs;
   assign idx_addr     = state_r.idx_addr;
   assign gpr_addr     = state_r.gpr_addr;
   assign probe_region = state_r.region;
   assign irq_take     = state_r.irq_take;

endmodule

/* bench/cpu_registers_properties.sv */
// Port checks for the CPU register file.
module cpu_registers_properties
#(
   parameter logic [15:0] GPR_BASE = 16'h0100
)
(
   input wire logic                                ref_clk,
   input wire logic                                resetn,
   input wire cpu_regs_pkg::dp_wr_type             dp_wr,
   input wire cpu_regs_pkg::alu_req_type           alu,
   input wire logic                                pc_step,
   input wire logic [cpu_regs_pkg::DATA_W-1:0]     idx_disp,
   input wire logic [cpu_regs_pkg::GPR_NUM_W-1:0]  gpr_num,
   input wire logic                                irq_req,
   input wire logic [1:0]                          irq_level,
   input wire cpu_regs_pkg::reg_file_type          regs,
   input wire logic [cpu_regs_pkg::DATA_W-1:0]     idx_addr,
   input wire logic [cpu_regs_pkg::DATA_W-1:0]     gpr_addr,
   input wire logic                                irq_take
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire logic [15:0] ps = regs.program_status;
   wire logic [15:0] acc = regs.accumulator;
   ////////////////////////////////////////
   sequence alu_go;
      alu.valid;
   endsequence
   sequence shl_go;
      alu.valid && alu.op == cpu_regs_pkg::ALU_SHL;
   endsequence
   a_pc_step:
      assert property (pc_step && !dp_wr.valid |=> regs.program_counter ==
         $past(regs.program_counter) + 16'h1) else $error("program counter did not step");
   a_byte_keep:
      assert property (alu_go ##0 alu.byte_op |=> acc[15:8] == $past(acc[15:8]))
         else $error("byte op changed the upper byte");
   a_zero_flag:
      assert property (alu_go |=> ps[2] == ($past(alu.byte_op) ? acc[7:0] == 8'h0 :
         acc == 16'h0)) else $error("zero flag wrong");
   a_neg_flag:
      assert property (alu_go |=> ps[3] == ($past(alu.byte_op) ? acc[7] : acc[15]))
         else $error("negative flag wrong");
   a_shl_carry:
      assert property (shl_go |=> ps[0] == ($past(alu.byte_op) ? $past(acc[7]) :
         $past(acc[15]))) else $error("shift carry wrong");
   a_idx_sum:
      assert property ($past(resetn) |-> idx_addr == $past(regs.index_register) +
         $past(idx_disp)) else $error("indexed address wrong");
   a_gpr_addr:
      assert property ($past(resetn) |-> gpr_addr == GPR_BASE + {$past(ps[12:8]), 3'h0} +
         $past(gpr_num)) else $error("bank register address wrong");
   a_irq_gate:
      assert property ($past(resetn) |-> irq_take == ($past(irq_req) && $past(ps[6]) &&
         $past(ps[5:4]) != 2'h3 && $past(irq_level) < $past(ps[5:4])))
         else $error("interrupt acceptance wrong");
   a_irq_reset:
      assert property ($rose(resetn) |-> !ps[6]) else $error("enable flag set after reset");
   a_ps_reserved:
      assert property (ps[15:13] == 3'h0) else $error("reserved status bits set");
endmodule
bind cpu_registers cpu_registers_properties #(.GPR_BASE(GPR_BASE)) props (.ref_clk, .resetn,
   .dp_wr, .alu, .pc_step, .idx_disp, .gpr_num, .irq_req, .irq_level, .regs, .idx_addr,
   .gpr_addr, .irq_take);

/* bench/datapath_model.sv */
// Execution datapath and interrupt source facing the register file.
module datapath_model
(
   input  wire logic                  ref_clk,
   output cpu_regs_pkg::dp_wr_type    dp_wr,
   output cpu_regs_pkg::alu_req_type  alu,
   output logic                       pc_step,
   output logic [15:0]                idx_disp,
   output logic [2:0]                 gpr_num,
   output logic [15:0]                probe_addr,
   output logic                       irq_req,
   output logic [1:0]                 irq_level
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {dp_wr, alu, pc_step, idx_disp, gpr_num, probe_addr, irq_req, irq_level} = '0;
   end
   ////////////////////////////////////////
   // issue pulses are held for one clock, then released; levels values are held until the next call.
   task automatic issue(input logic s, input cpu_regs_pkg::alu_req_type a,
                        input cpu_regs_pkg::dp_wr_type w);
      @(posedge ref_clk) {pc_step, alu, dp_wr} <= {s, a, w};
      @(posedge ref_clk) {pc_step, alu, dp_wr} <= '0;
   endtask
   task automatic levels(input logic [15:0] ds, input logic [2:0] n, input logic [15:0] pa,
                         input logic rq, input logic [1:0] lv);
      @(posedge ref_clk) {idx_disp, gpr_num, probe_addr, irq_req, irq_level} <= {ds, n, pa, rq, lv};
   endtask
endmodule

/* bench/cpu_registers_and_condition_codes_bench.sv */
// Self-checking bench for the CPU register file.
module cpu_registers_and_condition_codes_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] GB = 16'h0100;
   logic                        ref_clk;
   logic                        resetn;
   cpu_regs_pkg::bus_req_type   bus;
   logic [15:0]                 bus_rdata;
   cpu_regs_pkg::dp_wr_type     dp_wr;
   cpu_regs_pkg::alu_req_type   alu;
   logic                        pc_step;
   logic [15:0]                 idx_disp;
   logic [2:0]                  gpr_num;
   logic [15:0]                 probe_addr;
   logic                        irq_req;
   logic [1:0]                  irq_level;
   cpu_regs_pkg::reg_file_type  regs;
   logic [15:0]                 idx_addr;
   logic [15:0]                 gpr_addr;
   cpu_regs_pkg::region_type    probe_region;
   logic                        irq_take;
   int                          failures;
   int                          n_checks;
   logic [15:0]                 m [7];
   logic [15:0]                 d;
   logic [23:0]                 r;
   logic [2:0]                  op;
   logic                        b;
   logic [15:0]                 pa [8] = '{16'h0, 16'h7f, 16'h80, 16'h47f, 16'h480, 16'h7fff,
                                           16'h8000, 16'hffff};
   int                          pr [8] = '{0, 0, 1, 1, 3, 3, 2, 2};
   cpu_registers #(.GPR_BASE(GB)) uut (.ref_clk, .resetn, .bus, .bus_rdata, .dp_wr, .alu,
      .pc_step, .idx_disp, .gpr_num, .probe_addr, .irq_req, .irq_level, .regs, .idx_addr,
      .gpr_addr, .probe_region, .irq_take);
   datapath_model dp (.ref_clk, .dp_wr, .alu, .pc_step, .idx_disp, .gpr_num, .probe_addr,
      .irq_req, .irq_level);
   ////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial
   begin
      #(100 * 20000);
      failures++;
      tally_and_finish();
   end
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk) bus <= '{1'b1, 1'b0, a, v};
      @(posedge ref_clk) bus <= '0;
      if (a < 4'h7)
         m[a] = (a == 4'h6) ? (v & 16'h1fff) : v;
   endtask
   task automatic rd_all;
      for (int a = 0; a < 8; a++)
      begin
         @(posedge ref_clk) bus <= '{1'b0, 1'b1, a[3:0], 16'h0};
         @(posedge ref_clk) bus <= '0;
         @(negedge ref_clk);
         chk(bus_rdata, (a < 7) ? m[a] : 16'h0);
      end
   endtask
   // Reference arithmetic: result in the low 16 bits, condition byte above it.
   function automatic logic [23:0] alu_ref(input logic [2:0] o, input logic by,
                                           input logic [15:0] a, input logic [15:0] t,
                                           input logic [7:0] f);
      int w, av, tv, x;
      w = by ? 8 : 16;
      av = by ? a[7:0] : a;
      tv = by ? t[7:0] : t;
      x = o == 0 ? av + tv : o == 1 ? av - tv : o == 2 ? av << 1 : av >> 1;
      f[0] = o == 0 ? x >> w : o == 1 ? av < tv : o == 2 ? av >> (w - 1) : av;
      if (o < 2)
      begin
         f[7] = o[0] ? (av % 16 < tv % 16) : (av % 16 + tv % 16 > 15);
         f[1] = ((o[0] ? (av ^ tv) : ~(av ^ tv)) & (av ^ x)) >> (w - 1);
      end
      x = x & ((1 << w) - 1);
      f[2] = x == 0;
      f[3] = x >> (w - 1);
      return {f, by ? {a[15:8], x[7:0]} : x[15:0]};
   endfunction
   ////////////////////////////////////////
   initial
   begin
      failures = 0;
      n_checks = 0;
      resetn = 1'b0;
      bus = '0;
      m = '{default: 16'h0};
      void'($urandom(86));
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_all();
      $display("reset values done");
      for (int a = 0; a < 8; a++)
         wr(a[3:0], $urandom);
      rd_all();
      $display("register access done");
      repeat (60)
      begin
         wr(4'h1, $urandom);
         wr(4'h2, ($urandom % 3 == 0) ? m[1] : $urandom);
         op = $urandom % 4;
         b = $urandom;
         r = alu_ref(op, b, m[1], m[2], m[6][7:0]);
         dp.issue(1'b0, '{1'b1, cpu_regs_pkg::alu_op_type'(op), b}, '0);
         m[1] = r[15:0];
         m[6][7:0] = r[23:16];
         @(negedge ref_clk);
         chk({regs.program_status[7:0], regs.accumulator}, r);
      end
      $display("arithmetic done");
      for (int i = 0; i < 32; i++)
      begin
         wr(4'h6, {9'h0, i[4], i[3:2], 4'h0});
         dp.levels(16'h0, 3'h0, 16'h0, 1'b1, i[1:0]);
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(irq_take, i[4] && i[3:2] != 2'h3 && i[1:0] < i[3:2]);
      end
      $display("interrupt gate done");
      for (int i = 0; i < 8; i++)
      begin
         wr(4'h3, $urandom);
         wr(4'h6, {3'h0, 5'($urandom), 8'h0});
         d = $urandom;
         op = $urandom;
         dp.levels(d, op, pa[i], 1'b0, 2'h0);
         @(posedge ref_clk);
         @(negedge ref_clk);
         chk(idx_addr, 16'(m[3] + d));
         chk(gpr_addr, 16'(GB + {m[6][12:8], 3'h0} + op));
         chk(probe_region, pr[i]);
      end
      $display("address helpers done");
      wr(4'h0, 16'hfffe);
      dp.issue(1'b1, '0, '0);
      dp.issue(1'b1, '0, '{1'b1, 4'h5, 16'h5a5a});
      fork
         wr(4'h0, 16'h1234);
         dp.issue(1'b1, '0, '0);
      join
      fork
         wr(4'h1, 16'h1111);
         dp.issue(1'b0, '0, '{1'b1, 4'h1, 16'h2222});
      join
      @(negedge ref_clk);
      chk({regs.program_counter, regs.stack_pointer}, 32'h00005a5a);
      chk(regs.accumulator, 16'h2222);
      $display("step and priority done");
      wr(4'h6, 16'h00ff);
      @(posedge ref_clk) resetn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      m = '{default: 16'h0};
      rd_all();
      $display("second reset done");
      tally_and_finish();
   end
endmodule
